// *** include/counter_set_pkg.sv ***
// Purpose: shared constants, carriers and helpers for the counter set
// Assumes: 4-bit counters, 32-bit register port, byte addresses
// Notes:   register offsets are word aligned
package counter_set_pkg;

  // widths
  localparam int CNT_W  = 4;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int EVT_W  = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS     = 8'h00;
  localparam logic [ADDR_W-1:0] PRESET_OFS   = 8'h04;
  localparam logic [ADDR_W-1:0] COUNTS_OFS   = 8'h08;
  localparam logic [ADDR_W-1:0] LOADABLE_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] EVENTS_OFS   = 8'h10;

  // control register fields
  localparam int CTRL_SRC_BIT  = 0;
  localparam int CTRL_LOAD_BIT = 1;
  localparam int CTRL_EN_BIT   = 2;
  localparam int CTRL_OE_BIT   = 3;
  localparam int CTRL_W        = 4;

  // counts register field positions
  localparam int FLD_LSB  = 0;
  localparam int FLD_JOHN = 4;
  localparam int FLD_BIN  = 8;
  localparam int FLD_GRAY = 12;

  // loadable register fields
  localparam int FLD_LD_OE = 4;

  // events register field positions
  localparam int FLD_BIN_WRAP  = 0;
  localparam int FLD_JOHN_LAP  = 8;

  // reset values and other constants
  localparam logic [CTRL_W-1:0] CTRL_RST  = 4'h0;
  localparam logic [CNT_W-1:0]  COUNT_RST = 4'h0;
  localparam logic [EVT_W-1:0]  EVT_RST   = 8'h00;
  localparam logic [EVT_W-1:0]  EVT_ONE   = 8'h01;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 4'h1;
  localparam logic [CNT_W-1:0]  CNT_FULL  = 4'hF;
  localparam logic [CNT_W-1:0]  JOHN_LAST = 4'h1;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_type;

  // controls of the loadable counter
  typedef struct packed {
    logic             parallel_load_select;
    logic             count_en;
    logic             out_en;
    logic [CNT_W-1:0] parallel_preset_bus;
  } load_ctrl_type;

  // three-state pad drive
  typedef struct packed {
    logic [CNT_W-1:0] data;
    logic             oe_n;
  } pad_out_type;

  // reflected binary conversions
  function automatic logic [CNT_W-1:0] bin_to_gray(input logic [CNT_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [CNT_W-1:0] gray_to_bin(input logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b[CNT_W-1] = g[CNT_W-1];
    for (int i = CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// *** logic/four_bit_counter_set.sv ***
// Purpose: set of four-bit counters: toggle bit, Johnson ring, binary,
//          Gray and loadable, with a small register port
// Assumes: one 20 MHz clock; async_clear and control pins are asynchronous
// Notes:   async_clear clears every counter without the clock
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/100ps
module four_bit_counter_set (
  // clock and resets
  input  wire logic                               clk,
  input  wire logic                               rstn,
  input  wire logic                               async_clear,
  // register port
  input  wire counter_set_pkg::reg_req_type       req,
  output      logic [counter_set_pkg::DATA_W-1:0] rd_data,
  // loadable counter pins
  input  wire counter_set_pkg::load_ctrl_type     load_pins,
  output      counter_set_pkg::pad_out_type       three_state_pad_buffer,
  // free-running counter outputs
  output      logic                               lsb_count_bit,
  output      logic [counter_set_pkg::CNT_W-1:0]  johnson_q,
  output      logic [counter_set_pkg::CNT_W-1:0]  binary_q,
  output      logic [counter_set_pkg::CNT_W-1:0]  gray_q
);
  import counter_set_pkg::*;

  // whole module state in one word
  typedef struct packed {
    load_ctrl_type     pin_sync1;
    load_ctrl_type     pin_sync2;
    logic [CTRL_W-1:0] ctrl;
    logic [CNT_W-1:0]  preset;
    logic              toggle;
    logic [CNT_W-1:0]  johnson;
    logic [CNT_W-1:0]  binary;
    logic [CNT_W-1:0]  gray;
    logic [EVT_W-1:0]  bin_wraps;
    logic [EVT_W-1:0]  john_laps;
    logic [DATA_W-1:0] rdata;
  } top_state_type;

  top_state_type    state_ff;
  top_state_type    nxt_state;

  // signals between the pieces
  load_ctrl_type    ld_ctrl;
  logic [CNT_W-1:0] ld_value;
  logic [CNT_W-1:0] toggle_sel;
  logic [CNT_W-1:0] bin_next;
  logic             wr_hit_ctrl;
  logic             wr_hit_preset;
  logic             wr_hit_events;
  logic             bin_wrap_evt;
  logic             john_lap_evt;

  // address match used by the write decode; reads decode through a case
  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  // write decode
  assign wr_hit_ctrl   = req.wr && addr_is(req.addr, CTRL_OFS);
  assign wr_hit_preset = req.wr && addr_is(req.addr, PRESET_OFS);
  assign wr_hit_events = req.wr && addr_is(req.addr, EVENTS_OFS);

  // per-bit toggle select: AND of all lower bits
  genvar gi;
  generate
    for (gi = 0; gi < CNT_W; gi++) begin : g_bin
      if (gi == 0) begin : g_lsb
        // lowest bit toggles every edge
        assign toggle_sel[gi] = 1'b1;
      end else begin : g_upper
        assign toggle_sel[gi] = &state_ff.binary[gi-1:0];
      end
      // two-way selector: inverted on select high, true otherwise
      assign bin_next[gi] = toggle_sel[gi] ? ~state_ff.binary[gi]
                                           : state_ff.binary[gi];
    end
  endgenerate

  // events seen by the software counters
  assign bin_wrap_evt = (state_ff.binary == CNT_FULL);
  assign john_lap_evt = (state_ff.johnson == JOHN_LAST);

  // loadable controls from pins or from software
  always_comb begin
    if (state_ff.ctrl[CTRL_SRC_BIT]) begin
      ld_ctrl.parallel_load_select = state_ff.ctrl[CTRL_LOAD_BIT];
      ld_ctrl.count_en             = state_ff.ctrl[CTRL_EN_BIT];
      ld_ctrl.out_en               = state_ff.ctrl[CTRL_OE_BIT];
      ld_ctrl.parallel_preset_bus  = state_ff.preset;
    end else begin
      // otherwise the synchronised pins drive the loadable controls
      ld_ctrl = state_ff.pin_sync2;
    end
  end

  // next state of everything
  always_comb begin
    nxt_state = state_ff;

    // two flops before any pin is used
    nxt_state.pin_sync1 = load_pins;
    nxt_state.pin_sync2 = state_ff.pin_sync1;

    // single toggling bit, inverted feedback
    nxt_state.toggle = ~state_ff.toggle;

    // ring: shift up, last stage inverted into first
    nxt_state.johnson = {state_ff.johnson[CNT_W-2:0],
                         ~state_ff.johnson[CNT_W-1]};

    // binary through per-bit selectors
    nxt_state.binary = bin_next;

    // reflected code: decode, step, encode; one bit moves
    nxt_state.gray = bin_to_gray(gray_to_bin(state_ff.gray) + CNT_ONE);

    // software control and preset
    if (wr_hit_ctrl) begin
      nxt_state.ctrl = req.wdata[CTRL_W-1:0];
    end
    if (wr_hit_preset) begin
      nxt_state.preset = req.wdata[CNT_W-1:0];
    end

    // event counters: a write clears, a same-cycle event still counts
    if (bin_wrap_evt) begin
      nxt_state.bin_wraps = wr_hit_events ? EVT_ONE
                                          : state_ff.bin_wraps + EVT_ONE;
    end else if (wr_hit_events) begin
      nxt_state.bin_wraps = EVT_RST;
    end
    if (john_lap_evt) begin
      nxt_state.john_laps = wr_hit_events ? EVT_ONE
                                          : state_ff.john_laps + EVT_ONE;
    end else if (wr_hit_events) begin
      nxt_state.john_laps = EVT_RST;
    end

    // read data stands for one cycle only; unmapped reads zero
    nxt_state.rdata = WORD_ZERO;
    if (req.rd) begin
      case (req.addr)
        CTRL_OFS: begin
          nxt_state.rdata[CTRL_W-1:0] = state_ff.ctrl;
        end
        PRESET_OFS: begin
          nxt_state.rdata[CNT_W-1:0] = state_ff.preset;
        end
        COUNTS_OFS: begin
          nxt_state.rdata[FLD_LSB]            = state_ff.toggle;
          nxt_state.rdata[FLD_JOHN +: CNT_W]  = state_ff.johnson;
          nxt_state.rdata[FLD_BIN +: CNT_W]   = state_ff.binary;
          nxt_state.rdata[FLD_GRAY +: CNT_W]  = state_ff.gray;
        end
        LOADABLE_OFS: begin
          nxt_state.rdata[CNT_W-1:0] = ld_value;
          nxt_state.rdata[FLD_LD_OE] = ld_ctrl.out_en;
        end
        EVENTS_OFS: begin
          nxt_state.rdata[FLD_BIN_WRAP +: EVT_W] = state_ff.bin_wraps;
          nxt_state.rdata[FLD_JOHN_LAP +: EVT_W] = state_ff.john_laps;
        end
        default: begin
          nxt_state.rdata = WORD_ZERO;
        end
      endcase
    end
  end

  // clear reaches every flop without waiting for an edge;
  // the register port clears too, a trade for a single state word
  always_ff @(posedge clk or negedge rstn or posedge async_clear) begin
    if (!rstn || async_clear) begin
      state_ff.pin_sync1 <= '0;
      state_ff.pin_sync2 <= '0;
      state_ff.ctrl      <= CTRL_RST;
      state_ff.preset    <= COUNT_RST;
      state_ff.toggle    <= 1'b0;
      state_ff.johnson   <= COUNT_RST;
      state_ff.binary    <= COUNT_RST;
      state_ff.gray      <= COUNT_RST;
      state_ff.bin_wraps <= EVT_RST;
      state_ff.john_laps <= EVT_RST;
      state_ff.rdata     <= WORD_ZERO;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // loadable counter with its own four-way selector
  loadable_counter u_loadable (
    .clk         (clk),
    .rstn        (rstn),
    .async_clear (async_clear),
    .ctrl        (ld_ctrl),
    .pad         (three_state_pad_buffer),
    .count_value (ld_value)
  );

  // outputs straight from flops
  assign lsb_count_bit = state_ff.toggle;
  assign johnson_q     = state_ff.johnson;
  assign binary_q      = state_ff.binary;
  assign gray_q        = state_ff.gray;
  assign rd_data       = state_ff.rdata;

endmodule

// *** logic/loadable_counter.sv ***
// Purpose: four-bit loadable counter with count enable and three-state drive
// Assumes: controls already synchronised to clk
// Notes:   pad drives while oe_n is low
`timescale 1ns/100ps
module loadable_counter (
  // clock and resets
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic                          async_clear,
  // controls
  input  wire counter_set_pkg::load_ctrl_type ctrl,
  // outputs
  output      counter_set_pkg::pad_out_type   pad,
  output      logic [counter_set_pkg::CNT_W-1:0] count_value
);
  import counter_set_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] count;
  } ld_state_type;

  ld_state_type state_ff;
  ld_state_type nxt_state;
  logic [1:0]   mux_sel;

  // selector of the four-way input mux; load outranks enable
  assign mux_sel = {ctrl.parallel_load_select, ctrl.count_en};

  // next value through the four-way selector
  always_comb begin
    nxt_state = state_ff;
    case (mux_sel)
      2'b00: nxt_state.count = state_ff.count;
      2'b01: nxt_state.count = state_ff.count + CNT_ONE;
      2'b10: nxt_state.count = ctrl.parallel_preset_bus;
      2'b11: nxt_state.count = ctrl.parallel_preset_bus;
      default: nxt_state.count = state_ff.count;
    endcase
  end

  // clear acts without the clock
  always_ff @(posedge clk or negedge rstn or posedge async_clear) begin
    if (!rstn || async_clear) begin
      state_ff.count <= COUNT_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // data from flops, enable follows the control level
  assign pad.data    = state_ff.count;
  assign pad.oe_n    = ~ctrl.out_en;
  assign count_value = state_ff.count;

endmodule

// *** verification/counter_set_chk.sv ***
// Purpose: port assertions for the counter set
// Assumes: free counters advance on every edge out of clear
// Notes:   clear checks stay live while async_clear is high
`timescale 1ns/100ps
module counter_set_chk (
  // clock and resets
  input wire logic                              clk,
  input wire logic                              rstn,
  input wire logic                              async_clear,
  // watched outputs
  input wire counter_set_pkg::pad_out_type      three_state_pad_buffer,
  input wire logic                              lsb_count_bit,
  input wire logic [counter_set_pkg::CNT_W-1:0] johnson_q,
  input wire logic [counter_set_pkg::CNT_W-1:0] binary_q,
  input wire logic [counter_set_pkg::CNT_W-1:0] gray_q
);
  import counter_set_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn || async_clear);
  // clear needs no edge, so it is sampled while still high
  property p_clear;
    disable iff (!rstn) async_clear |-> {johnson_q, binary_q, gray_q} == 12'h000;
  endproperty
  property p_clr_pad;
    disable iff (!rstn) async_clear |-> !lsb_count_bit && three_state_pad_buffer.data == 4'h0;
  endproperty
  // the edge that releases reset or clear still clears, so it starts no step
  property p_lsb;
    rstn && !async_clear |=> lsb_count_bit != $past(lsb_count_bit);
  endproperty
  property p_john;
    rstn && !async_clear |=> johnson_q == {$past(johnson_q[2:0]), !$past(johnson_q[3])};
  endproperty
  property p_jvalid;
    johnson_q inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF, 4'hE, 4'hC, 4'h8};
  endproperty
  property p_bin;
    rstn && !async_clear |=> binary_q == $past(binary_q) + 4'h1;
  endproperty
  property p_gstep;
    rstn && !async_clear |=> $countones(gray_q ^ $past(gray_q)) == 1;
  endproperty
  // both start at zero and step together, so gray mirrors binary
  property p_gord;
    gray_q == (binary_q ^ (binary_q >> 1));
  endproperty
  a_clear:   assert property (p_clear) else $error("counters not cleared");
  a_clr_pad: assert property (p_clr_pad) else $error("bit or pad not cleared");
  a_lsb:     assert property (p_lsb) else $error("lsb did not toggle");
  a_john:    assert property (p_john) else $error("johnson shift wrong");
  a_jvalid:  assert property (p_jvalid) else $error("johnson state illegal");
  a_bin:     assert property (p_bin) else $error("binary step wrong");
  a_gstep:   assert property (p_gstep) else $error("gray step not one bit");
  a_gord:    assert property (p_gord) else $error("gray order wrong");
  c_jlast:   cover property (johnson_q == 4'h8);
  c_wrap:    cover property (binary_q == 4'hF ##1 binary_q == 4'h0);
  c_drive:   cover property (three_state_pad_buffer.oe_n == 1'b0);
endmodule
bind four_bit_counter_set counter_set_chk counter_set_chk_inst (
  .clk(clk), .rstn(rstn), .async_clear(async_clear),
  .three_state_pad_buffer(three_state_pad_buffer), .lsb_count_bit(lsb_count_bit),
  .johnson_q(johnson_q), .binary_q(binary_q), .gray_q(gray_q));

// *** verification/testbench.sv ***
// Purpose: directed bench for the counter set
// Assumes: pins reach the loadable counter on the third edge
// Notes:   counter and pad outputs are looked at on the falling edge, read data 1 ns after the rising edge
`timescale 1ns/100ps
module testbench;
  import counter_set_pkg::*;
  logic              clk, rstn, async_clear, lsb;
  reg_req_type       req;
  load_ctrl_type     load_pins;
  pad_out_type       pad;
  logic [DATA_W-1:0] rd_data;
  logic [CNT_W-1:0]  jq, bq, gq;
  int                num_errors, check_count;
  localparam logic [3:0] JSEQ [8] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF, 4'hE, 4'hC, 4'h8};

  four_bit_counter_set four_bit_counter_set_inst (
    .clk(clk), .rstn(rstn), .async_clear(async_clear), .req(req), .rd_data(rd_data),
    .load_pins(load_pins), .three_state_pad_buffer(pad), .lsb_count_bit(lsb),
    .johnson_q(jq), .binary_q(bq), .gray_q(gq));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string what, input logic [DATA_W-1:0] exp, got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // each access ends one idle cycle later so strobes never collide
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                        input string what);
    req <= '{addr: a, wdata: WORD_ZERO, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(what, exp, rd_data);
    @(posedge clk);
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the hundred or so cycles needed
  initial begin
    #150000;
    num_errors++;
    test_done();
  end

  initial begin
    rstn = 1'b0;
    async_clear = 1'b0;
    req = '0;
    load_pins = '0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk("oe_n in reset", 32'h1, 32'(pad.oe_n));
    @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    reg_rd(CTRL_OFS, 32'h0, "ctrl reset");
    reg_rd(PRESET_OFS, 32'h0, "preset reset");
    reg_rd(8'h14, 32'h0, "unmapped");
    // clear lands before any edge
    async_clear <= 1'b1;
    @(negedge clk);
    chk("cleared", 32'h0, 32'({bq, gq, jq, lsb}));
    @(posedge clk);
    async_clear <= 1'b0;
    for (int k = 0; k < 18; k++) begin
      @(negedge clk);
      chk("toggle", 32'(k % 2), 32'(lsb));
      chk("johnson", 32'(JSEQ[k % 8]), 32'(jq));
      chk("binary", 32'(k % 16), 32'(bq));
      chk("gray", 32'((k % 16) ^ ((k % 16) >> 1)), 32'(gq));
    end
    // one binary wrap seen at edge 16, johnson laps at edges 2, 10 and 18
    @(posedge clk);
    reg_rd(EVENTS_OFS, 32'h0301, "events");
    // software drive: load together with enable
    @(posedge clk);
    reg_wr(PRESET_OFS, 32'hA);
    reg_wr(CTRL_OFS, 32'hF);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("load wins", 32'hA, 32'(pad.data));
    chk("oe_n on", 32'h0, 32'(pad.oe_n));
    @(posedge clk);
    reg_rd(CTRL_OFS, 32'hF, "ctrl back");
    reg_rd(LOADABLE_OFS, 32'h1A, "loadable");
    reg_wr(CTRL_OFS, 32'hD);
    @(negedge clk);
    chk("count", 32'hB, 32'(pad.data));
    repeat (5) @(negedge clk);
    chk("wrap", 32'h0, 32'(pad.data));
    @(posedge clk);
    reg_wr(CTRL_OFS, 32'h9);
    repeat (4) @(negedge clk);
    // the old enable still counts once more on the edge that takes the write
    chk("hold", 32'h2, 32'(pad.data));
    @(posedge clk);
    reg_wr(CTRL_OFS, 32'h1);
    @(negedge clk);
    chk("oe_n off", 32'h1, 32'(pad.oe_n));
    @(posedge clk);
    reg_rd(LOADABLE_OFS, 32'h02, "loadable off");
    // pin drive through the synchroniser
    reg_wr(CTRL_OFS, 32'h0);
    load_pins <= '{1'b1, 1'b0, 1'b1, 4'h6};
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("pin load", 32'h0D, 32'({pad.data, ~pad.oe_n}));
    @(posedge clk);
    load_pins.parallel_load_select <= 1'b0;
    load_pins.count_en <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("pin count", 32'hA, 32'(pad.data));
    @(posedge clk);
    load_pins.out_en <= 1'b0;
    repeat (3) @(negedge clk);
    chk("pin oe_n off", 32'h1, 32'(pad.oe_n));
    @(posedge clk);
    async_clear <= 1'b1;
    @(negedge clk);
    chk("pad cleared", 32'h0, 32'(pad.data));
    test_done();
  end
endmodule
